// ==== rtl/tccc_pkg.sv ====
// Constants and types for the timer capture/compare channel block
// Behaviour
// RULE_01: Chan3 select: output, input3, input4, trigger
// RULE_02: Chan4 select: output, input4, input3, trigger
// RULE_03: Software changes select only while disabled
// RULE_04: Chan3 divider captures every 1/2/4/8 events
// RULE_05: Four-bit filter fields at 7:4, 15:12
// RULE_06: Chan4 divider held in bits 11:10
// RULE_07: Chan4 divider uses chan3 coding
// RULE_08: Output channel enable gates compare output
// RULE_09: Input channel enable gates capture load
// RULE_10: Output polarity: 0 high, 1 low
// RULE_11: Software keeps complement polarity clear on outputs
// RULE_12: Polarity pair selects input active edge
// RULE_13: Enable bit layout per channel, reserved bits
// RULE_14: Disabled output low, enable deasserted
// RULE_15: Pad level also depends on pin config
// RULE_16: Enable register resets to zero
// RULE_17: Counter readable, writable, resets zero
// RULE_18: Accepted capture loads counter into channel register
package tccc_pkg;
   localparam int          NCH          = 4;
   localparam int          AW           = 8;
   localparam logic [7:0]  OFS_MODE34   = 8'h1c;
   localparam logic [7:0]  OFS_ENABLE   = 8'h20;
   localparam logic [7:0]  OFS_COUNT    = 8'h24;
   localparam logic [7:0]  OFS_CAP0     = 8'h34;
   localparam logic [7:0]  OFS_CAP_STEP = 8'h04;
   localparam logic [15:0] RST_ZERO     = 16'h0000;
   localparam logic [15:0] ENA_RSV_MASK = 16'hbbbb;
   localparam int          SEL3_LSB     = 0;
   localparam int          DIV3_LSB     = 2;
   localparam int          FLT3_LSB     = 4;
   localparam int          SEL4_LSB     = 8;
   localparam int          DIV4_LSB     = 10;
   localparam int          FLT4_LSB     = 12;
   localparam int          ENA_STRIDE   = 4;
   localparam int          POL_OFS      = 1;
   localparam int          NPOL_OFS     = 3;
   typedef enum logic [1:0] {
      TCCC_SEL_OUT, TCCC_SEL_OWN, TCCC_SEL_PAIR, TCCC_SEL_TRG
   } tccc_sel_t;
endpackage

// ==== rtl/tccc_top.sv ====
// Capture/compare channel configuration, enable gating and counter register
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module tccc_top
   import tccc_pkg::*;
(
   input  wire logic                       clock,
   input  wire logic                       arst_n,
   input  wire logic [tccc_pkg::AW-1:0]    reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_write,
   input  wire logic                       reg_read,
   output logic      [31:0]                reg_rdata,
   input  wire logic [tccc_pkg::NCH-1:0]   timer_input_pin,
   input  wire logic                       internal_trigger_source,
   input  wire logic [tccc_pkg::NCH-1:0]   compare_reference,
   output logic      [tccc_pkg::NCH-1:0]   compare_output,
   output logic      [tccc_pkg::NCH-1:0]   compare_output_enable,
   output logic      [tccc_pkg::NCH-1:0]   capture_event
);
   import tccc_pkg::*;

   logic [15:0] mode34_ff;
   logic [15:0] enable_ff;
   logic [15:0] count_ff;
   logic [15:0] cap_ff [NCH];
   logic [NCH-1:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;
   logic        trg_s1_ff, trg_s2_ff, trg_prev_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   // Address decode
   wire wr_mode  = reg_write && (reg_addr == OFS_MODE34);
   wire wr_ena   = reg_write && (reg_addr == OFS_ENABLE);
   wire wr_count = reg_write && (reg_addr == OFS_COUNT);

   // Field extraction for channels 3 and 4
   wire tccc_sel_t   sel3 = tccc_sel_t'(mode34_ff[SEL3_LSB +: 2]); // RULE_01
   wire tccc_sel_t   sel4 = tccc_sel_t'(mode34_ff[SEL4_LSB +: 2]); // RULE_02
   wire logic [1:0]  div3 = mode34_ff[DIV3_LSB +: 2]; // RULE_04
   wire logic [1:0]  div4 = mode34_ff[DIV4_LSB +: 2]; // RULE_06 RULE_07
   wire logic [3:0]  flt3 = mode34_ff[FLT3_LSB +: 4]; // RULE_05
   wire logic [3:0]  flt4 = mode34_ff[FLT4_LSB +: 4]; // RULE_05

   // Synchronised trigger edge
   wire trg_rise = trg_s2_ff & ~trg_prev_ff;
   wire trg_fall = ~trg_s2_ff & trg_prev_ff;

   // Mode register; channels 1 and 2 have no mode field here and act as plain outputs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mode34_ff <= RST_ZERO;
      end else if (wr_mode) begin
         mode34_ff <= reg_wdata[15:0]; // RULE_03
      end
   end

   // Enable register, reserved bits forced to zero
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         enable_ff <= RST_ZERO; // RULE_16
      end else if (wr_ena) begin
         enable_ff <= reg_wdata[15:0] & ENA_RSV_MASK; // RULE_13
      end
   end

   // Counter register, software access only in this block
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_ff <= RST_ZERO; // RULE_17
      end else if (wr_count) begin
         count_ff <= reg_wdata[15:0]; // RULE_17
      end
   end

   // Pin and trigger synchronisers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_ff   <= '0;
         pin_s2_ff   <= '0;
         pin_prev_ff <= '0;
         trg_s1_ff   <= 1'b0;
         trg_s2_ff   <= 1'b0;
         trg_prev_ff <= 1'b0;
      end else begin
         pin_s1_ff   <= timer_input_pin;
         pin_s2_ff   <= pin_s1_ff;
         pin_prev_ff <= pin_s2_ff;
         trg_s1_ff   <= internal_trigger_source;
         trg_s2_ff   <= trg_s1_ff;
         trg_prev_ff <= trg_s2_ff;
      end
   end

   // Per-channel enable, polarity, output gating and capture
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic [2:0] evt_cnt_ff;
         logic       en, pol, npol, is_in, rise, fall, edge_ok, take;
         logic       own_rise, own_fall, pair_rise, pair_fall;
         logic [1:0] div;
         logic [2:0] evt_last;
         tccc_sel_t  sel;
         localparam int PAIR = g ^ 1;
         assign en   = enable_ff[g*ENA_STRIDE];
         assign pol  = enable_ff[g*ENA_STRIDE + POL_OFS];
         assign npol = enable_ff[g*ENA_STRIDE + NPOL_OFS];
         assign sel  = (g == 2) ? sel3 : ((g == 3) ? sel4 : TCCC_SEL_OUT);
         assign div  = (g == 2) ? div3 : ((g == 3) ? div4 : 2'b00);
         assign is_in = (sel != TCCC_SEL_OUT);
         assign own_rise  = pin_s2_ff[g] & ~pin_prev_ff[g];
         assign own_fall  = ~pin_s2_ff[g] & pin_prev_ff[g];
         assign pair_rise = pin_s2_ff[PAIR] & ~pin_prev_ff[PAIR];
         assign pair_fall = ~pin_s2_ff[PAIR] & pin_prev_ff[PAIR];
         // Input routing: own pin, paired pin or internal trigger
         assign rise = (sel == TCCC_SEL_OWN)  ? own_rise  :
                       (sel == TCCC_SEL_PAIR) ? pair_rise :
                       (sel == TCCC_SEL_TRG)  ? trg_rise  : 1'b0; // RULE_01 RULE_02
         assign fall = (sel == TCCC_SEL_OWN)  ? own_fall  :
                       (sel == TCCC_SEL_PAIR) ? pair_fall :
                       (sel == TCCC_SEL_TRG)  ? trg_fall  : 1'b0;
         // Edge select: 00 rising, 01 falling, 11 both, 10 rising
         assign edge_ok = (pol & npol) ? (rise | fall) :
                          pol ? fall : rise; // RULE_12
         // Divider: last event count 0, 1, 3, 7
         assign evt_last = 3'((1 << div) - 1); // RULE_04 RULE_07
         assign take = is_in && en && edge_ok && (evt_cnt_ff == evt_last); // RULE_09
         assign capture_event[g] = take;
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               evt_cnt_ff <= 3'h0;
            end else if (!(is_in && en)) begin
               evt_cnt_ff <= 3'h0;
            end else if (edge_ok) begin
               evt_cnt_ff <= take ? 3'h0 : 3'(evt_cnt_ff + 3'h1); // RULE_04
            end
         end
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               cap_ff[g] <= RST_ZERO;
            end else if (take) begin
               cap_ff[g] <= count_ff; // RULE_18
            end
         end
         // Output gating; pad level is then set by pin muxing outside
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               compare_output[g]        <= 1'b0;
               compare_output_enable[g] <= 1'b0;
            end else begin
               compare_output[g]        <= (!is_in && en) ?
                                           (compare_reference[g] ^ pol) : 1'b0; // RULE_10 RULE_14
               compare_output_enable[g] <= !is_in && en; // RULE_08 RULE_14 RULE_15
            end
         end
      end
   endgenerate

   // Read mux; capture registers are read-only here
   wire [AW-1:0] cap_ofs = reg_addr - OFS_CAP0;
   wire [AW-1:0] cap_idx = cap_ofs / OFS_CAP_STEP;
   wire          cap_hit = (reg_addr >= OFS_CAP0) && ((cap_ofs % OFS_CAP_STEP) == '0) &&
                           (cap_idx < AW'(NCH));
   always_comb begin
      nxt_rdata = 32'h0;
      if (reg_addr == OFS_MODE34) begin
         nxt_rdata[15:0] = mode34_ff;
      end else if (reg_addr == OFS_ENABLE) begin
         nxt_rdata[15:0] = enable_ff;
      end else if (reg_addr == OFS_COUNT) begin
         nxt_rdata[15:0] = count_ff;
      end else if (cap_hit) begin
         nxt_rdata[15:0] = cap_ff[cap_idx[1:0]];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= 32'h0;
      end else begin
         rdata_ff <= reg_read ? nxt_rdata : 32'h0;
      end
   end
   assign reg_rdata = rdata_ff;

   // Filter fields are stored only; sampling is outside this block
   wire unused_flt = ^{flt3, flt4};
endmodule

// ==== bench/tccc_asserts.sv ====
// Port-level checker for the capture/compare channel block
`timescale 1ns/1ps
module tccc_asserts
   import tccc_pkg::*;
(
   input wire logic                     clock,
   input wire logic                     arst_n,
   input wire logic [tccc_pkg::AW-1:0]  reg_addr,
   input wire logic [31:0]              reg_wdata,
   input wire logic                     reg_write,
   input wire logic                     reg_read,
   input wire logic [31:0]              reg_rdata,
   input wire logic [tccc_pkg::NCH-1:0] compare_reference,
   input wire logic [tccc_pkg::NCH-1:0] compare_output,
   input wire logic [tccc_pkg::NCH-1:0] compare_output_enable,
   input wire logic [tccc_pkg::NCH-1:0] capture_event
);
   logic [15:0] ena_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Mirror of the enable register, used to judge the gating
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) ena_ff <= 16'h0000;
      else if (reg_write && reg_addr == OFS_ENABLE) ena_ff <= reg_wdata[15:0];
   end
   a_rdata_idle: assert property (
      !$past(reg_read) |-> reg_rdata == 32'h0) else $error("read data outside slot");
   a_rdata_upper: assert property (
      reg_rdata[31:16] == 16'h0) else $error("upper read bits set");
   a_rsv_zero: assert property (
      $past(reg_read) && $past(reg_addr) == OFS_ENABLE |-> (reg_rdata & 32'h4444) == 32'h0)
      else $error("reserved enable bits read back");
   a_off_low: assert property (
      (compare_output & ~compare_output_enable) == 4'h0) else $error("disabled output high");
   a_oe_follow: assert property (
      compare_output_enable[1:0] == {$past(ena_ff[4]), $past(ena_ff[0])})
      else $error("output enable wrong");
   a_pol_apply: assert property (
      compare_output[1:0] == ({$past(ena_ff[4]), $past(ena_ff[0])}
      & ($past(compare_reference[1:0]) ^ {$past(ena_ff[5]), $past(ena_ff[1])})))
      else $error("output polarity wrong");
   a_oe_gate: assert property (
      (compare_output_enable[3:2] & ~{$past(ena_ff[12]), $past(ena_ff[8])}) == 2'b00)
      else $error("output enabled while off");
   a_cap_gate: assert property (
      (capture_event & ~{ena_ff[12], ena_ff[8], 2'b00}) == 4'h0) else $error("capture while off");
endmodule
bind tccc_top tccc_asserts chk (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .compare_reference, .compare_output, .compare_output_enable,
   .capture_event);

// ==== bench/tccc_pins.sv ====
// Pin-side model making clean input edges on the timer pins and trigger
`timescale 1ns/1ps
module tccc_pins (
   input  wire logic clock,
   output logic [3:0] pin,
   output logic       trg
);
   initial pin = 4'h0;
   initial trg = 1'b0;
   // Drive source s (4 is the trigger) to level v, held long enough for the sync
   task automatic drive(input int s, input logic v);
      @(posedge clock);
      if (s == 4) trg <= v; else pin[s] <= v;
      repeat (4) @(posedge clock);
   endtask
   // Rising then falling edge on source s
   task automatic pulse(input int s);
      drive(s, 1'b1);
      drive(s, 1'b0);
   endtask
endmodule

// ==== bench/tccc_top_tb.sv ====
// Self-checking bench for the capture/compare channel block
`timescale 1ns/1ps
module tccc_top_tb;
   import tccc_pkg::*;
   logic        clock, arst_n, wr, rd, pend;
   logic [7:0]  adr;
   logic [31:0] wd, expq[$];
   logic [3:0]  cref, ex;
   logic [15:0] lfsr, capv[5];
   wire  [31:0] rdt;
   wire  [3:0]  pin, co, coe, ce;
   wire         trg;
   int          n_errors, num_checks;
   tccc_top dut (.clock, .arst_n, .reg_addr(adr), .reg_wdata(wd), .reg_write(wr),
      .reg_read(rd), .reg_rdata(rdt), .timer_input_pin(pin), .internal_trigger_source(trg),
      .compare_reference(cref), .compare_output(co), .compare_output_enable(coe),
      .capture_event(ce));
   tccc_pins pins (.clock, .pin, .trg);
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      {wr, adr, wd} <= {1'b1, a, 16'h0000, d};
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      {rd, adr} <= {1'b1, a};
      expq.push_back(e);
      @(posedge clock);
      rd <= 1'b0;
   endtask
   // Channel as input: no capture before the nth event, capture on it, none once disabled;
   // pl is {complement, polarity}: 0 rising, 1 falling, 3 both (both only with dv 0)
   task automatic cap(input int ch, input int sel, input int dv, input int pl);
      int src;
      logic [15:0] v;
      src = (sel == 3) ? 4 : (ch + sel) % 2 + 2;
      wreg(OFS_ENABLE, 16'h0000);
      wreg(OFS_MODE34, 16'((sel + 4 * dv) << (8 * (ch - 3))));
      wreg(OFS_ENABLE, 16'((1 + 2 * (pl % 2) + 8 * (pl / 2)) << (4 * (ch - 1))));
      lfsr = nx(lfsr);
      v = (pl == 0) ? lfsr : ~lfsr;
      wreg(OFS_COUNT, lfsr);
      repeat ((1 << dv) - 1) pins.pulse(src);
      rreg(8'(48 + 4 * ch), {16'h0000, capv[ch]});
      pins.drive(src, 1'b1);
      rreg(8'(48 + 4 * ch), {16'h0000, (pl == 1) ? capv[ch] : lfsr});
      wreg(OFS_COUNT, ~lfsr);
      pins.drive(src, 1'b0);
      capv[ch] = v;
      rreg(8'(48 + 4 * ch), {16'h0000, v});
      wreg(OFS_ENABLE, 16'h0000);
      wreg(OFS_COUNT, ~v);
      pins.pulse(src);
      rreg(8'(48 + 4 * ch), {16'h0000, v});
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) pend <= rd;
   // Matches each read answer with the oldest noted expectation
   always @(negedge clock) if (pend === 1'b1) check(rdt, expq.pop_front());
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      wrap_up();
   end
   initial begin
      {arst_n, wr, rd, adr, wd, cref} = {3'h0, 8'h00, 32'h0, 4'h0};
      lfsr = 16'h0014;
      foreach (capv[i]) capv[i] = 16'h0000;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      rreg(OFS_ENABLE, 32'h0);
      rreg(OFS_COUNT, 32'h0);
      wreg(OFS_COUNT, 16'ha5c3);
      rreg(OFS_COUNT, 32'h0000a5c3);
      wreg(OFS_ENABLE, 16'h7777);
      rreg(OFS_ENABLE, 32'h00003333);
      wreg(OFS_ENABLE, 16'h0000);
      wreg(OFS_MODE34, 16'hf5a6);
      rreg(OFS_MODE34, 32'h0000f5a6);
      rreg(8'h08, 32'h0);
      wreg(OFS_MODE34, 16'h0000);
      // Random enables and polarities on output channels, complement bits kept clear
      repeat (8) begin
         lfsr = nx(lfsr);
         wreg(OFS_ENABLE, lfsr & 16'h7777);
         cref <= lfsr[15:12] ^ lfsr[3:0];
         ex = {lfsr[12], lfsr[8], lfsr[4], lfsr[0]};
         @(posedge clock);
         @(negedge clock);
         check({28'h0, coe}, {28'h0, ex});
         check({28'h0, co}, {28'h0, ex & (cref ^ {lfsr[13], lfsr[9], lfsr[5], lfsr[1]})});
      end
      for (int ch = 3; ch < 5; ch++) begin
         for (int k = 0; k < 4; k++) begin
            cap(ch, (k == 0) ? 1 : k, k, (k == 0) ? 3 : ((k == 1) ? 1 : 0));
         end
      end
      repeat (4) @(posedge clock);
      wrap_up();
   end
endmodule
